//--- rtl/rxq_pkg.sv
// Package of constants for the receive stream qualifier block
package rxq_pkg;
    localparam int RXQ_DATA_W = 256;
    localparam int RXQ_PAR_W = 32;
    localparam int RXQ_QW_W = 64;
    localparam int RXQ_EMPTY_W = 2;
    localparam int RXQ_READY_DELAY = 2;
    localparam int RXQ_FIFO_DEPTH = 4;
    localparam logic [1:0] RXQ_EMPTY_NONE = 2'h0;
    localparam logic [1:0] RXQ_EMPTY_ONE = 2'h1;
    localparam logic [1:0] RXQ_EMPTY_TWO = 2'h2;
    localparam logic [1:0] RXQ_EMPTY_THREE = 2'h3;
    localparam logic [1:0] RXQ_RESET_EMPTY = 2'h0;
    localparam logic [1:0] RXQ_RESET_PIPE = 2'h0;
    typedef enum logic [1:0] {
        RXQ_IDLE = 2'b00,
        RXQ_MID = 2'b01
    } rxq_pkt_e;
endpackage : rxq_pkg

//--- rtl/rxq_fifo.sv
// Small valid/ready FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module rxq_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("rxq_fifo depth must be a power of two of 2 or more");
    end
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic [WIDTH-1:0] dout_r, dout_nxt;
    logic ov_r, ov_nxt;
    logic push, pop_mem;

    // Output stage is a register; memory feeds it when empty or draining
    always_comb begin
        push = in_valid_i && (cnt_r != (AW+1)'(DEPTH));
        pop_mem = (cnt_r != '0) && (!ov_r || out_ready_i);
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop_mem ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop_mem);
        dout_nxt = pop_mem ? mem_r[rp_r] : dout_r;
        ov_nxt = pop_mem ? 1'b1 : (ov_r && !out_ready_i);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            dout_r <= '0;
            ov_r <= 1'b0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            dout_r <= dout_nxt;
            ov_r <= ov_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = ov_r;
    assign out_data_o = dout_r;
endmodule : rxq_fifo
`default_nettype wire

//--- rtl/rxq_top.sv
// Receive stream qualifier: valid, markers, parity, empty and error
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: Valid marks exactly the cycles words transfer
// R2: Valid drops within 2 clocks of ready low
// R3: Valid returns within 2 clocks of ready
// R4: Parity driven only when parity option enabled
// R5: Parity bit n is odd parity byte n
// R6: Empty counts unused top quadwords at packet end
// R7: Code 00: all 256 bits valid
// R8: Code 01: bits 191..0 valid
// R9: Code 10: bits 127..0 valid
// R10: Code 11: only bits 63..0 valid
// R11: Error flag marks uncorrectable error in TLP
// R12: First marker on first TLP transfer
// R13: Last marker on final TLP transfer
// R14: Ready sampled two cycles before transfer
// R15: Application drops ready to throttle
// R16: Parity computed from and aligned with word
module rxq_top
    import rxq_pkg::*;
#(
    parameter bit PARITY_EN = 1'b1,
    parameter int DEPTH = RXQ_FIFO_DEPTH
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic SRC_VALID_I,
    output logic SRC_READY_O,
    input wire logic [RXQ_DATA_W-1:0] SRC_WORD_I,
    input wire logic SRC_FIRST_I,
    input wire logic SRC_LAST_I,
    input wire logic [RXQ_EMPTY_W-1:0] SRC_EMPTY_I,
    input wire logic SRC_ERROR_I,
    input wire logic RX_SINK_READY_I,
    output logic RX_WORD_VALID_O,
    output logic [RXQ_DATA_W-1:0] RX_TLP_WORD_O,
    output logic [RXQ_PAR_W-1:0] RX_BYTE_PARITY_O,
    output logic RX_TLP_FIRST_O,
    output logic RX_TLP_LAST_O,
    output logic [RXQ_EMPTY_W-1:0] RX_EMPTY_QWORDS_O,
    output logic RX_TLP_ERROR_O
);
    localparam int FW = RXQ_DATA_W + RXQ_EMPTY_W + 3;

    initial begin
        if (DEPTH != RXQ_FIFO_DEPTH)
            $error("rxq_top fifo depth must be four");
    end

    // Odd parity per byte: bit set when byte holds even ones
    function automatic logic [RXQ_PAR_W-1:0] odd_par(
        input logic [RXQ_DATA_W-1:0] w);
        logic [RXQ_PAR_W-1:0] p;
        p = '0;
        for (int i = 0; i < RXQ_PAR_W; i++) begin
            p[i] = ~(^w[i*8 +: 8]); // R5
        end
        return p;
    endfunction : odd_par

    // Empty code is only meaningful on a last cycle; else all valid
    function automatic logic [1:0] empty_code(input logic last,
                                              input logic [1:0] e);
        logic [1:0] c;
        c = RXQ_EMPTY_NONE; // R7
        if (last) begin
            unique case (e)
                RXQ_EMPTY_NONE: c = RXQ_EMPTY_NONE; // R7
                RXQ_EMPTY_ONE: c = RXQ_EMPTY_ONE; // R8
                RXQ_EMPTY_TWO: c = RXQ_EMPTY_TWO; // R9
                RXQ_EMPTY_THREE: c = RXQ_EMPTY_THREE; // R10
            endcase
        end
        return c;
    endfunction : empty_code

    logic [FW-1:0] fin, fout;
    logic f_valid, f_ready, f_in_ready;
    logic src_take;

    // Only a word offered while the source sees ready is written
    assign src_take = SRC_VALID_I && SRC_READY_O;

    assign fin = {SRC_ERROR_I, SRC_FIRST_I, SRC_LAST_I, SRC_EMPTY_I,
                  SRC_WORD_I};

    rxq_fifo #(
        .WIDTH(FW),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .in_valid_i(src_take),
        .in_ready_o(f_in_ready),
        .in_data_i(fin),
        .out_valid_o(f_valid),
        .out_ready_i(f_ready),
        .out_data_o(fout)
    );

    // Ready delay line: ready seen at n grants a transfer at n+2
    logic [RXQ_READY_DELAY-1:0] rdy_pipe_r, rdy_pipe_nxt;
    logic grant;

    always_comb begin
        rdy_pipe_nxt = {rdy_pipe_r[RXQ_READY_DELAY-2:0], RX_SINK_READY_I};
        grant = rdy_pipe_r[RXQ_READY_DELAY-1]; // R14
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rdy_pipe_r <= RXQ_RESET_PIPE;
        end else begin
            rdy_pipe_r <= rdy_pipe_nxt;
        end
    end

    // Output stage: word is loaded so it shows in the granted cycle.
    // Grant is known one cycle early from the first pipe stage.
    logic early_grant;
    logic load;
    logic valid_r, valid_nxt;
    logic [RXQ_DATA_W-1:0] word_r, word_nxt;
    logic [RXQ_PAR_W-1:0] par_r, par_nxt;
    logic first_r, first_nxt, last_r, last_nxt, err_r, err_nxt;
    logic [RXQ_EMPTY_W-1:0] empty_r, empty_nxt;

    always_comb begin
        early_grant = rdy_pipe_r[RXQ_READY_DELAY-2];
        load = early_grant && f_valid; // R2 R3
        f_ready = early_grant;
        valid_nxt = load; // R1
        word_nxt = word_r;
        par_nxt = par_r;
        first_nxt = 1'b0;
        last_nxt = 1'b0;
        err_nxt = 1'b0;
        empty_nxt = RXQ_RESET_EMPTY;
        if (load) begin
            word_nxt = fout[RXQ_DATA_W-1:0];
            if (PARITY_EN) begin
                par_nxt = odd_par(fout[RXQ_DATA_W-1:0]); // R4 R16
            end
            last_nxt = fout[RXQ_DATA_W+2]; // R13
            first_nxt = fout[RXQ_DATA_W+3]; // R12
            err_nxt = fout[RXQ_DATA_W+4]; // R11
            empty_nxt = empty_code(fout[RXQ_DATA_W+2],
                                   fout[RXQ_DATA_W +: 2]); // R6
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            valid_r <= 1'b0;
            word_r <= '0;
            par_r <= '0;
            first_r <= 1'b0;
            last_r <= 1'b0;
            err_r <= 1'b0;
            empty_r <= RXQ_RESET_EMPTY;
        end else begin
            valid_r <= valid_nxt;
            word_r <= word_nxt;
            par_r <= par_nxt;
            first_r <= first_nxt;
            last_r <= last_nxt;
            err_r <= err_nxt;
            empty_r <= empty_nxt;
        end
    end

    // Source ready is fifo space registered, ANDed with the current fifo space
    logic src_rdy_r;
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            src_rdy_r <= 1'b0;
        end else begin
            src_rdy_r <= f_in_ready;
        end
    end

    assign SRC_READY_O = src_rdy_r && f_in_ready;
    assign RX_WORD_VALID_O = valid_r;
    assign RX_TLP_WORD_O = word_r;
    assign RX_BYTE_PARITY_O = par_r;
    assign RX_TLP_FIRST_O = first_r;
    assign RX_TLP_LAST_O = last_r;
    assign RX_EMPTY_QWORDS_O = empty_r;
    assign RX_TLP_ERROR_O = err_r;
    logic unused_grant;
    assign unused_grant = grant;
endmodule : rxq_top
`default_nettype wire

//--- sim/rxq_top_properties.sv
// Port checker of the receive stream qualifier
`timescale 1ns/1ps
`default_nettype none
module rxq_top_properties
    import rxq_pkg::*;
#(
    parameter bit PARITY_EN = 1'b1
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic RX_SINK_READY_I,
    input wire logic RX_WORD_VALID_O,
    input wire logic [RXQ_DATA_W-1:0] RX_TLP_WORD_O,
    input wire logic [RXQ_PAR_W-1:0] RX_BYTE_PARITY_O,
    input wire logic RX_TLP_FIRST_O,
    input wire logic RX_TLP_LAST_O,
    input wire logic [RXQ_EMPTY_W-1:0] RX_EMPTY_QWORDS_O,
    input wire logic RX_TLP_ERROR_O
);
    logic [RXQ_PAR_W-1:0] par_exp;
    always_comb begin
        for (int b = 0; b < RXQ_PAR_W; b++) begin
            par_exp[b] = ~^RX_TLP_WORD_O[8*b +: 8];
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    property p_lat; RX_WORD_VALID_O |-> $past(RX_SINK_READY_I, 2); endproperty
    a_lat: assert property (p_lat) else $error("valid early");
    property p_drop; $fell(RX_SINK_READY_I) |-> ##2 !RX_WORD_VALID_O; endproperty
    a_drop: assert property (p_drop) else $error("valid late drop");
    property p_first; RX_TLP_FIRST_O |-> RX_WORD_VALID_O; endproperty
    a_first: assert property (p_first) else $error("first alone");
    property p_last; RX_TLP_LAST_O |-> RX_WORD_VALID_O; endproperty
    a_last: assert property (p_last) else $error("last alone");
    property p_err; RX_TLP_ERROR_O |-> RX_WORD_VALID_O; endproperty
    a_err: assert property (p_err) else $error("error alone");
    property p_empty;
        RX_EMPTY_QWORDS_O != 2'h0 |-> RX_WORD_VALID_O && RX_TLP_LAST_O;
    endproperty
    a_empty: assert property (p_empty) else $error("empty off end");
    property p_par;
        RX_WORD_VALID_O |-> RX_BYTE_PARITY_O == (PARITY_EN ? par_exp : '0);
    endproperty
    a_par: assert property (p_par) else $error("bad parity");
    property p_hold; !RX_WORD_VALID_O |-> $stable(RX_TLP_WORD_O); endproperty
    a_hold: assert property (p_hold) else $error("word moved");
endmodule : rxq_top_properties
bind rxq_top rxq_top_properties #(.PARITY_EN(PARITY_EN)) i_rxq_top_properties (
    .CLK_I, .RSTN_I, .RX_SINK_READY_I, .RX_WORD_VALID_O, .RX_TLP_WORD_O,
    .RX_BYTE_PARITY_O, .RX_TLP_FIRST_O, .RX_TLP_LAST_O, .RX_EMPTY_QWORDS_O,
    .RX_TLP_ERROR_O);
`default_nettype wire

//--- sim/rxq_app_model.sv
// Application side model that throttles with sink ready
`timescale 1ns/1ps
`default_nettype none
module rxq_app_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic accept_i,
    output logic ready_o
);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= accept_i;
        end
    end
endmodule : rxq_app_model
`default_nettype wire

//--- sim/test_rxq_top.sv
// Testbench of the receive stream qualifier
`timescale 1ns/1ps
`default_nettype none
module test_rxq_top
    import rxq_pkg::*;
;
    logic CLK_I = 1'b0, RSTN_I = 1'b0, SRC_VALID_I = 1'b0, SRC_FIRST_I = 1'b0;
    logic SRC_LAST_I = 1'b0, SRC_ERROR_I = 1'b0, acc = 1'b0, refused = 1'b0;
    logic [RXQ_DATA_W-1:0] SRC_WORD_I = '0;
    logic [1:0] SRC_EMPTY_I = 2'h0, rh = 2'h0;
    logic SRC_READY_O, RX_SINK_READY_I, RX_WORD_VALID_O, RX_TLP_FIRST_O;
    logic RX_TLP_LAST_O, RX_TLP_ERROR_O;
    logic [RXQ_DATA_W-1:0] RX_TLP_WORD_O;
    logic [RXQ_PAR_W-1:0] RX_BYTE_PARITY_O;
    logic [1:0] RX_EMPTY_QWORDS_O;
    logic [260:0] e, exp_q[$];
    int error_cnt = 0, checked = 0;
    rxq_top i_rxq_top (.CLK_I, .RSTN_I, .SRC_VALID_I, .SRC_READY_O, .SRC_WORD_I,
        .SRC_FIRST_I, .SRC_LAST_I, .SRC_EMPTY_I, .SRC_ERROR_I, .RX_SINK_READY_I,
        .RX_WORD_VALID_O, .RX_TLP_WORD_O, .RX_BYTE_PARITY_O, .RX_TLP_FIRST_O,
        .RX_TLP_LAST_O, .RX_EMPTY_QWORDS_O, .RX_TLP_ERROR_O);
    rxq_app_model i_rxq_app_model (.clk_i(CLK_I), .rstn_i(RSTN_I),
        .accept_i(acc), .ready_o(RX_SINK_READY_I));
    initial forever #12.5 CLK_I = ~CLK_I;
    task automatic chk_w(input logic [255:0] x, g);
        checked++;
        if (x !== g) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask : chk_w
    task automatic chk_f(input logic [31:0] x, g);
        checked++;
        if (x !== g) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask : chk_f
    task automatic end_sim;
        $display("errors=%0d checks=%0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    task automatic hang;
        error_cnt++;
        end_sim();
    endtask : hang
    function automatic logic [31:0] par(input logic [255:0] w);
        for (int b = 0; b < 32; b++) par[b] = ~^w[8*b +: 8];
    endfunction : par
    // Offer one word and hold it until the source side takes it
    task automatic send(input logic [260:0] x);
        int n;
        SRC_VALID_I <= 1'b1;
        {SRC_FIRST_I, SRC_LAST_I, SRC_EMPTY_I, SRC_ERROR_I, SRC_WORD_I} <= x;
        for (n = 0; n < 40; n++) begin
            @(negedge CLK_I);
            if (SRC_READY_O === 1'b1) break;
            refused = 1'b1;
        end
        if (n == 40) hang();
        @(posedge CLK_I);
        exp_q.push_back(x);
    endtask : send
    task automatic drain;
        for (int n = 0; n < 60 && exp_q.size() > 0; n++) @(negedge CLK_I);
        if (exp_q.size() > 0) hang();
        @(posedge CLK_I);
    endtask : drain
    always @(posedge CLK_I) begin
        rh <= {rh[0], RX_SINK_READY_I};
        if (RSTN_I && RX_WORD_VALID_O === 1'b1) begin
            chk_f(32'(rh[1]), 32'h1);
            if (exp_q.size() == 0) begin
                chk_f(32'h0, 32'h1);
            end else begin
                e = exp_q.pop_front();
                chk_w(e[255:0], RX_TLP_WORD_O);
                chk_f(par(e[255:0]), RX_BYTE_PARITY_O);
                chk_f(32'(e[260:256]), {27'h0, RX_TLP_FIRST_O, RX_TLP_LAST_O,
                    RX_EMPTY_QWORDS_O, RX_TLP_ERROR_O});
            end
        end
    end
    // Two-word packets back to back, one per empty code
    task automatic s_codes;
        logic [255:0] w;
        acc <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            w = {8{32'h1f2e3d4c}} + 256'(c * 977);
            send({2'b10, 2'h0, 1'b0, w});
            send({2'b01, 2'(c), c == 2, ~w});
        end
        SRC_VALID_I <= 1'b0;
        drain();
    endtask : s_codes
    // Stall the sink until the buffer refuses, then resume
    task automatic s_fill;
        int n;
        acc <= 1'b0;
        refused = 1'b0;
        fork
            begin
                for (int k = 0; k < 8; k++) begin
                    send({2'b11, 2'h3, 1'b0, {32{8'(k)}}});
                end
                SRC_VALID_I <= 1'b0;
            end
            begin
                repeat (15) @(posedge CLK_I);
                chk_f(32'(refused), 32'h1); // Full buffer refuses
                acc <= 1'b1;
                for (n = 0; n < 8 && RX_WORD_VALID_O !== 1'b1; n++) begin
                    @(negedge CLK_I);
                end
                chk_f(32'(n <= 4), 32'h1);
            end
        join
        drain();
    endtask : s_fill
    initial begin
        repeat (3) @(posedge CLK_I);
        RSTN_I <= 1'b1;
        @(posedge CLK_I);
        s_codes();
        s_fill();
        end_sim();
    end
endmodule : test_rxq_top
`default_nettype wire
